/* inc/ubm_pkg.sv */
`default_nettype none
package ubm_pkg;
    // ==========================================================
    // widths
    localparam int DATA_W = 8;
    localparam int PROD_W = 16;
    localparam int INSTR_W = 16;
    localparam int BANK_W = 4;
    localparam int ADDR_W = 12;

    // ==========================================================
    // opcode fields
    localparam logic [7:0] OPC_LIT_HI = 8'h0d;
    localparam logic [6:0] OPC_REG_HI = 7'h01;
    localparam int OPC_HI_POS = 8;
    localparam int OPC_REG_POS = 9;
    localparam int BANK_SEL_POS = 8;

    // ==========================================================
    // access bank split: low half from bank 0, upper half from the top bank
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

    // ==========================================================
    // reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [11:0] ADDR_RST = 12'h000;

    // ==========================================================
    // quarter-cycle sequencer
    typedef enum logic [4:0] {
        UBM_IDLE = 5'b00001,
        UBM_Q1 = 5'b00010,
        UBM_Q2 = 5'b00100,
        UBM_Q3 = 5'b01000,
        UBM_Q4 = 5'b10000
    } ubm_state_t;
endpackage : ubm_pkg
`default_nettype wire

/* inc/ubm_mul_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface ubm_mul_if;
    logic [7:0] multiplicand;
    logic [7:0] multiplier;
    logic [15:0] product;
    modport ctrl (output multiplicand, output multiplier, input product);
    modport array (input multiplicand, input multiplier, output product);
endinterface : ubm_mul_if
`default_nettype wire

/* core/ubm_mul_array.sv */
`timescale 1ns/10ps
`default_nettype none
module ubm_mul_array (
    ubm_mul_if.array mul
);
    // ==========================================================
    // shift-add partial products, purely combinational
    logic [15:0] partial [0:7];
    logic [15:0] sum [0:8];

    assign sum[0] = ubm_pkg::WORD_RST;

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_pp
            // unsigned: no sign extension of either operand
            assign partial[i] = mul.multiplier[i]
                ? (16'({8'h00, mul.multiplicand}) << i) : ubm_pkg::WORD_RST;
            assign sum[i + 1] = 16'(sum[i] + partial[i]);
        end
    endgenerate

    // 8x8 product always fits 16 bits, so nothing overflows
    assign mul.product = sum[8];
endmodule : ubm_mul_array
`default_nettype wire

/* core/ubm_multiplier.sv */
`timescale 1ns/10ps
`default_nettype none
// Operation
// - literal multiply: accumulator times 8-bit literal into product pair, high byte upper
// - register multiply: accumulator times addressed register, both operands left unchanged
// - no status flag, carry, overflow or zero indication; accumulator untouched
// - operand from access bank when bit clear, else bank select register bank
module ubm_multiplier (
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [7:0] accumulator,
    input wire logic [3:0] bank_select_register,
    input wire logic [7:0] mem_rdata,
    output logic instr_ready,
    output logic [11:0] mem_addr,
    output logic mem_rd,
    output logic [7:0] product_high_byte,
    output logic [7:0] product_low_byte,
    output logic product_write,
    output logic done
);
    // ==========================================================
    // decode of the incoming word
    logic is_lit;
    logic is_reg;
    logic take;

    assign is_lit = (instr[15:ubm_pkg::OPC_HI_POS] == ubm_pkg::OPC_LIT_HI);
    assign is_reg = (instr[15:ubm_pkg::OPC_REG_POS] == ubm_pkg::OPC_REG_HI);
    // other opcodes are ignored; ready stays high for them
    assign take = clk_en && instr_valid && instr_ready && (is_lit || is_reg);

    // ==========================================================
    // sequencer and datapath state
    ubm_pkg::ubm_state_t state_q;
    ubm_pkg::ubm_state_t state_d;
    logic [15:0] instr_q;
    logic [15:0] instr_d;
    logic [7:0] acc_q;
    logic [7:0] acc_d;
    logic [3:0] bank_q;
    logic [3:0] bank_d;
    logic [7:0] operand_q;
    logic [7:0] operand_d;
    logic [15:0] result_q;
    logic [15:0] result_d;
    logic reg_op_q;
    logic reg_op_d;
    logic ready_q;
    logic ready_d;
    logic [11:0] addr_q;
    logic [11:0] addr_d;
    logic rd_q;
    logic rd_d;
    logic [7:0] prod_hi_q;
    logic [7:0] prod_hi_d;
    logic [7:0] prod_lo_q;
    logic [7:0] prod_lo_d;
    logic wr_q;
    logic wr_d;
    logic done_q;
    logic done_d;

    ubm_mul_if mul_bus ();

    ubm_mul_array u_array (
        .mul(mul_bus.array)
    );

    assign mul_bus.multiplicand = acc_q;
    assign mul_bus.multiplier = operand_q;

    // ==========================================================
    // next-state logic
    always_comb begin
        state_d = state_q;
        instr_d = instr_q;
        acc_d = acc_q;
        bank_d = bank_q;
        operand_d = operand_q;
        result_d = result_q;
        reg_op_d = reg_op_q;
        ready_d = ready_q;
        addr_d = addr_q;
        rd_d = rd_q;
        prod_hi_d = prod_hi_q;
        prod_lo_d = prod_lo_q;
        wr_d = 1'b0;
        done_d = 1'b0;
        case (state_q)
            ubm_pkg::UBM_IDLE: begin
                if (take) begin
                    // operands captured once; the core's copies are never written
                    instr_d = instr;
                    acc_d = accumulator;
                    bank_d = bank_select_register;
                    reg_op_d = is_reg;
                    ready_d = 1'b0;
                    state_d = ubm_pkg::UBM_Q1;
                end
            end
            ubm_pkg::UBM_Q1: begin
                // decode: form the operand address
                if (!instr_q[ubm_pkg::BANK_SEL_POS]) begin
                    // bank select register overridden by the access bank
                    addr_d = {(instr_q[7:0] < ubm_pkg::ACCESS_SPLIT)
                        ? ubm_pkg::ACCESS_LOW_BANK : ubm_pkg::ACCESS_HIGH_BANK,
                        instr_q[7:0]};
                end else begin
                    addr_d = {bank_q, instr_q[7:0]};
                end
                rd_d = reg_op_q;
                state_d = ubm_pkg::UBM_Q2;
            end
            ubm_pkg::UBM_Q2: begin
                // read: register data or literal field
                operand_d = reg_op_q ? mem_rdata : instr_q[7:0];
                rd_d = 1'b0;
                state_d = ubm_pkg::UBM_Q3;
            end
            ubm_pkg::UBM_Q3: begin
                result_d = mul_bus.product;
                state_d = ubm_pkg::UBM_Q4;
            end
            ubm_pkg::UBM_Q4: begin
                // both bytes land together, never a torn pair
                prod_hi_d = result_q[15:8];
                prod_lo_d = result_q[7:0];
                wr_d = 1'b1;
                done_d = 1'b1;
                ready_d = 1'b1;
                state_d = ubm_pkg::UBM_IDLE;
            end
            default: begin
                ready_d = 1'b1;
                rd_d = 1'b0;
                state_d = ubm_pkg::UBM_IDLE;
            end
        endcase
    end

    // ==========================================================
    // registers; clock enable freezes everything
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= ubm_pkg::UBM_IDLE;
            instr_q <= ubm_pkg::WORD_RST;
            acc_q <= ubm_pkg::BYTE_RST;
            bank_q <= ubm_pkg::ACCESS_LOW_BANK;
            operand_q <= ubm_pkg::BYTE_RST;
            result_q <= ubm_pkg::WORD_RST;
            reg_op_q <= 1'b0;
            ready_q <= 1'b1;
            addr_q <= ubm_pkg::ADDR_RST;
            rd_q <= 1'b0;
            prod_hi_q <= ubm_pkg::BYTE_RST;
            prod_lo_q <= ubm_pkg::BYTE_RST;
            wr_q <= 1'b0;
            done_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            instr_q <= instr_d;
            acc_q <= acc_d;
            bank_q <= bank_d;
            operand_q <= operand_d;
            result_q <= result_d;
            reg_op_q <= reg_op_d;
            ready_q <= ready_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
            prod_hi_q <= prod_hi_d;
            prod_lo_q <= prod_lo_d;
            wr_q <= wr_d;
            done_q <= done_d;
        end
    end

    // no flag outputs exist at all, so nothing can signal carry or zero
    assign instr_ready = ready_q;
    assign mem_addr = addr_q;
    assign mem_rd = rd_q;
    assign product_high_byte = prod_hi_q;
    assign product_low_byte = prod_lo_q;
    assign product_write = wr_q;
    assign done = done_q;

    // ==========================================================
    // checks
    a_product_value: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_q == ubm_pkg::UBM_Q4) |=>
        ({product_high_byte, product_low_byte}
            == 16'($past(acc_q)) * 16'($past(operand_q))))
        else $error("product pair does not match operands");

    a_literal_operand: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_q == ubm_pkg::UBM_Q2 && !reg_op_q) |=>
        (operand_q == $past(instr_q[7:0])))
        else $error("literal operand not taken from instruction");

    a_register_operand: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_q == ubm_pkg::UBM_Q2 && reg_op_q) |=>
        (operand_q == $past(mem_rdata)))
        else $error("register operand not taken from memory");

    a_acc_held: assert property (@(posedge clock) disable iff (rst)
        (state_q != ubm_pkg::UBM_IDLE && $past(state_q) != ubm_pkg::UBM_IDLE)
        |-> $stable(acc_q))
        else $error("accumulator copy changed during multiply");

    a_access_bank: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_q == ubm_pkg::UBM_Q1
            && !instr_q[ubm_pkg::BANK_SEL_POS] && instr_q[7]) |=>
        (mem_addr[11:8] == ubm_pkg::ACCESS_HIGH_BANK))
        else $error("access bank upper half misaddressed");

    a_bank_select: assert property (@(posedge clock) disable iff (rst)
        (clk_en && state_q == ubm_pkg::UBM_Q1 && instr_q[ubm_pkg::BANK_SEL_POS]) |=>
        (mem_addr == {bank_q, instr_q[7:0]}))
        else $error("bank select register not used");

    a_four_quarters: assert property (@(posedge clock) disable iff (rst)
        (take && state_q == ubm_pkg::UBM_IDLE) ##1 clk_en [*4] |=>
        (product_write && done))
        else $error("multiply did not finish in four quarters");

    a_read_in_q2: assert property (@(posedge clock) disable iff (rst)
        mem_rd |-> (state_q == ubm_pkg::UBM_Q2 && reg_op_q))
        else $error("operand read outside second quarter");

    a_write_pulse: assert property (@(posedge clock) disable iff (rst)
        product_write |-> (state_q == ubm_pkg::UBM_IDLE && instr_ready))
        else $error("product write outside completion");
endmodule : ubm_multiplier
`default_nettype wire

/* verification/test_unsigned_byte_multiplier.sv */
`timescale 1ns/10ps
`default_nettype none
module test_unsigned_byte_multiplier;
    // ==========================================================
    // stimulus and observed signals
    logic clock, rst, clk_en, instr_valid;
    logic [15:0] instr;
    logic [7:0] accumulator, mem_rdata, product_high_byte, product_low_byte;
    logic [3:0] bank_select_register;
    logic [11:0] mem_addr;
    logic instr_ready, mem_rd, product_write, done;
    int bad_count = 0;
    int check_count = 0;

    ubm_multiplier uut (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .instr_valid(instr_valid),
        .instr(instr),
        .accumulator(accumulator),
        .bank_select_register(bank_select_register),
        .mem_rdata(mem_rdata),
        .instr_ready(instr_ready),
        .mem_addr(mem_addr),
        .mem_rd(mem_rd),
        .product_high_byte(product_high_byte),
        .product_low_byte(product_low_byte),
        .product_write(product_write),
        .done(done)
    );

    // ==========================================================
    // shared helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    // one multiply, judged edge by edge; accumulator and bank scrambled after the take
    task automatic run_op(input logic [15:0] ins, input logic [7:0] acc, input logic [3:0] bank,
            input logic [7:0] rd, input logic [11:0] addr, input logic isreg);
        logic [15:0] prev;
        logic [15:0] expv;
        prev = {product_high_byte, product_low_byte};
        expv = {8'h00, acc} * {8'h00, (isreg ? rd : ins[7:0])};
        @(posedge clock);
        instr <= ins;
        accumulator <= acc;
        bank_select_register <= bank;
        mem_rdata <= rd;
        instr_valid <= 1'b1;
        @(posedge clock);
        instr_valid <= 1'b0;
        accumulator <= ~acc;
        bank_select_register <= ~bank;
        for (int k = 1; k <= 5; k++) begin
            @(posedge clock);
            #1;
            check("done", 16'(done), 16'(k == 4));
            check("product_write", 16'(product_write), 16'(k == 4));
            check("busy ready", 16'(instr_ready), 16'(k >= 4));
            check("mem_rd", 16'(mem_rd), 16'(isreg && k == 1));
            if (isreg && k == 1) check("mem_addr", 16'(mem_addr), 16'(addr));
            if (k == 3) check("early product", {product_high_byte, product_low_byte}, prev);
        end
        check("product", {product_high_byte, product_low_byte}, expv);
        check("ready", 16'(instr_ready), 16'h0001);
    endtask : run_op

    // ==========================================================
    // scenarios
    task automatic t_literal;
        run_op(16'h0dc4, 8'he2, 4'h3, 8'h11, 12'h000, 1'b0);
        run_op(16'h0dff, 8'hff, 4'h3, 8'h11, 12'h000, 1'b0);
        run_op(16'h0d00, 8'h5a, 4'h3, 8'h11, 12'h000, 1'b0);
    endtask : t_literal

    // access bank both halves, then the bank register path
    task automatic t_register;
        run_op(16'h0212, 8'hc4, 4'h7, 8'hb5, 12'h012, 1'b1);
        run_op(16'h029c, 8'hff, 4'h7, 8'hff, 12'hf9c, 1'b1);
        run_op(16'h0334, 8'h81, 4'h7, 8'h02, 12'h734, 1'b1);
    endtask : t_register

    task automatic t_refuse;
        logic [15:0] prev;
        prev = {product_high_byte, product_low_byte};
        @(posedge clock);
        instr <= 16'h0e5a;
        instr_valid <= 1'b1;
        for (int k = 1; k <= 12; k++) begin
            @(posedge clock);
            if (k == 6) instr <= 16'h0400;
            if (k == 12) instr_valid <= 1'b0;
            #1;
            check("refused done", 16'(done | product_write | mem_rd), 16'h0000);
        end
        check("refused product", {product_high_byte, product_low_byte}, prev);
    endtask : t_refuse

    // enable low freezes the sequence; only enabled edges count
    task automatic t_stall;
        @(posedge clock);
        instr <= 16'h0d10;
        accumulator <= 8'h10;
        instr_valid <= 1'b1;
        @(posedge clock);
        instr_valid <= 1'b0;
        clk_en <= 1'b0;
        for (int k = 1; k <= 8; k++) begin
            @(posedge clock);
            if (k == 3) clk_en <= 1'b1;
            #1;
            check("stalled done", 16'(done), 16'(k == 7));
        end
        check("stalled product", {product_high_byte, product_low_byte}, 16'h0100);
    endtask : t_stall

    // second take on the completion cycle of the first
    task automatic t_back;
        @(posedge clock);
        instr <= 16'h0d03;
        accumulator <= 8'h05;
        instr_valid <= 1'b1;
        @(posedge clock);
        for (int k = 1; k <= 11; k++) begin
            @(posedge clock);
            // second word must stand during the completion cycle to be taken there
            if (k == 4) instr <= 16'h0d07;
            if (k == 4) accumulator <= 8'h09;
            if (k == 5) instr_valid <= 1'b0;
            #1;
            check("b2b done", 16'(done), 16'(k == 4 || k == 9));
            if (k == 4) check("b2b first", {product_high_byte, product_low_byte}, 16'h000f);
        end
        check("b2b second", {product_high_byte, product_low_byte}, 16'h003f);
    endtask : t_back

    // ==========================================================
    // clock, watchdog, main sequence
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // the whole run needs well under a thousand cycles
    initial begin
        #(20000 * 10);
        bad_count++;
        stop_test();
    end

    initial begin
        rst = 1'b1;
        clk_en = 1'b0;
        instr_valid = 1'b0;
        instr = 16'h0000;
        accumulator = 8'h00;
        bank_select_register = 4'h0;
        mem_rdata = 8'h00;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        clk_en <= 1'b1;
        @(posedge clock);
        #1;
        check("reset outputs", {product_high_byte, product_low_byte}, 16'h0000);
        check("reset ready", 16'(instr_ready), 16'h0001);
        t_literal();
        t_register();
        t_refuse();
        t_stall();
        t_back();
        stop_test();
    end
endmodule : test_unsigned_byte_multiplier
`default_nettype wire
